// ---- hdl/ptl_regs.vh ----
/*
 Constants shared by the target local interface and its write FIFO.
 Assumes inclusion by bare name from files in the same folder.
*/
`ifndef PTL_REGS_VH
`define PTL_REGS_VH

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PTL_RST_ADDR 32'h0000_0000
`define PTL_RST_DATA 32'h0000_0000
`define PTL_RST_CMD 4'h0
`define PTL_BEN_NONE 4'hf

// ----------------------------------------------------------------
// Field positions and steps
// ----------------------------------------------------------------
`define PTL_CMD_WR_BIT 0
`define PTL_ADDR_STEP 32'h0000_0004
`define PTL_DATA_W 32
`define PTL_BEN_W 4
`define PTL_FIFO_W 36
`define PTL_FIFO_DEPTH 8
`define PTL_FIFO_AW 3

`endif

// ---- hdl/ptl_fifo.v ----
/*
 Parameterised synchronous FIFO with valid/ready on both sides.
 Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`include "ptl_regs.vh"

module ptl_fifo #(
  parameter WIDTH = `PTL_FIFO_W,
  parameter DEPTH = `PTL_FIFO_DEPTH,
  parameter AW = `PTL_FIFO_AW
) (
  input wire i_clk,
  input wire i_nrst,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0] count_ff;
  wire push;
  wire pop;

  assign o_in_ready = (count_ff != DEPTH[AW:0]);
  assign o_out_valid = (count_ff != {(AW+1){1'b0}});
  assign o_out_data = mem_ff[rd_ptr_ff];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  // Pointer wrap for depths that are not a power of two
  function [AW-1:0] ptr_inc;
    input [AW-1:0] p;
    begin
      if (p == DEPTH[AW-1:0] - {{(AW-1){1'b0}}, 1'b1}) begin
        ptr_inc = {AW{1'b0}};
      end else begin
        ptr_inc = p + {{(AW-1){1'b0}}, 1'b1};
      end
    end
  endfunction

  always @(posedge i_clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= i_in_data;
    end
  end

  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_ff <= ptr_inc(wr_ptr_ff);
      end
      if (pop) begin
        rd_ptr_ff <= ptr_inc(rd_ptr_ff);
      end
      if (push && !pop) begin
        count_ff <= count_ff + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count_ff <= count_ff - {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule // ptl_fifo

// ---- hdl/ptl_target_local.v ----
/*
 Target local-side interface: hands claimed PCI target transactions to
 local peripheral logic with separate read and write data buses.
 Assumes the PCI pins are synchronous to I_REF_CLK (the PCI clock), an
 external decoder flags address hits, and a pad ring resolves the
 output enables into the shared PCI wires.
*/
`timescale 1ns/1ps
`include "ptl_regs.vh"

module ptl_target_local #(
  parameter FIFO_DEPTH = `PTL_FIFO_DEPTH,
  parameter FIFO_AW = `PTL_FIFO_AW
) (
  input wire I_REF_CLK,
  input wire I_NRST,
  input wire I_PCI_FRAME_N,
  input wire I_PCI_IRDY_N,
  input wire [31:0] I_PCI_AD,
  input wire [3:0] I_PCI_CBE_N,
  input wire I_PCI_ADDR_HIT,
  output wire [31:0] O_PCI_AD,
  output wire O_PCI_AD_OE,
  output wire O_PCI_DEVSEL_N,
  output wire O_PCI_TRDY_N,
  output wire O_PCI_STOP_N,
  output wire O_PCI_CTRL_OE,
  input wire [31:0] I_LOCAL_READ_DATA_IN,
  input wire I_LOCAL_READY_N,
  input wire I_LOCAL_ABORT_REQUEST_N,
  input wire I_LOCAL_DISCONNECT_REQUEST_N,
  output wire O_LOCAL_TRANSACTION_FRAME_N,
  output wire O_CORE_ACKNOWLEDGE_N,
  output wire O_LOCAL_IRDY_REG_N,
  output wire [31:0] O_LOCAL_WRITE_DATA_OUT,
  output wire [31:0] O_LOCAL_TARGET_ADDRESS,
  output wire [3:0] O_LOCAL_BUS_COMMAND,
  output wire [3:0] O_LOCAL_BYTE_ENABLES_N
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_CLAIM = 3'h1;
  localparam ST_DATA = 3'h2;
  localparam ST_STOP = 3'h3;
  localparam ST_ABORT = 3'h4;
  localparam ST_DRAIN = 3'h5;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg lframe_ff;
  reg nxt_lframe;
  reg devsel_ff;
  reg nxt_devsel;
  reg stop_ff;
  reg nxt_stop;
  reg turn_ff;
  reg nxt_turn;
  reg rtrdy_ff;
  reg nxt_rtrdy;
  reg rd_ff;
  reg nxt_rd;
  reg [3:0] cmd_ff;
  reg [3:0] nxt_cmd;
  reg [31:0] addr_ff;
  reg [31:0] nxt_addr;
  reg [31:0] rdata_ff;
  reg [31:0] nxt_rdata;
  reg [3:0] ben_ff;
  reg [3:0] nxt_ben;
  reg irdy_n_ff;
  reg frame_d_ff;

  // ----------------------------------------------------------------
  // Decodes
  // ----------------------------------------------------------------
  wire frame_act;
  wire irdy_act;
  wire lrdy_act;
  wire abort_req;
  wire disc_req;
  wire addr_phase;
  wire in_data;
  wire wr_ok;
  wire trdy_act;
  wire pci_xfer;
  wire ack_rd;
  wire ack_wr;
  wire ack_act;
  wire local_xfer;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire fifo_push;
  wire [35:0] fifo_out_data;

  // Bit of the command that separates writes from reads
  function is_write;
    input [3:0] cmd;
    begin
      is_write = cmd[`PTL_CMD_WR_BIT];
    end
  endfunction

  assign frame_act = ~I_PCI_FRAME_N;
  assign irdy_act = ~I_PCI_IRDY_N;
  assign lrdy_act = ~I_LOCAL_READY_N;
  assign abort_req = ~I_LOCAL_ABORT_REQUEST_N;
  assign disc_req = ~I_LOCAL_DISCONNECT_REQUEST_N;
  assign addr_phase = frame_act & ~frame_d_ff & (state_ff == ST_IDLE);
  assign in_data = (state_ff == ST_DATA);

  // ----------------------------------------------------------------
  // PCI handshake
  // ----------------------------------------------------------------
  // Write TRDY needs FIFO room and an active local ready
  assign wr_ok = in_data & ~rd_ff & fifo_in_ready & lrdy_act;
  assign trdy_act = in_data & (rd_ff ? rtrdy_ff : wr_ok);
  assign pci_xfer = irdy_act & trdy_act;
  assign fifo_push = pci_xfer & ~rd_ff;

  // ----------------------------------------------------------------
  // Local handshake
  // ----------------------------------------------------------------
  // Read: accept new data unless a word waits on a stalled master or in the last data phase
  assign ack_rd = in_data & rd_ff & (~rtrdy_ff | (irdy_act & frame_act));
  // Write: a buffered word is valid on the output bus
  assign ack_wr = ~rd_ff & lframe_ff & fifo_out_valid;
  assign ack_act = ack_rd | ack_wr;
  assign local_xfer = ack_act & lrdy_act;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always @* begin
    nxt_state = state_ff;
    nxt_lframe = lframe_ff;
    nxt_devsel = devsel_ff;
    nxt_stop = stop_ff;
    nxt_turn = 1'b0;
    nxt_rtrdy = rtrdy_ff;
    nxt_rd = rd_ff;
    nxt_cmd = cmd_ff;
    nxt_addr = addr_ff;
    nxt_rdata = rdata_ff;
    nxt_ben = ben_ff;
    if (local_xfer) begin
      nxt_addr = addr_ff + `PTL_ADDR_STEP;
    end
    if (in_data && rd_ff && irdy_act) begin
      nxt_ben = I_PCI_CBE_N;
    end
    if (rd_ff && pci_xfer) begin
      nxt_rtrdy = 1'b0;
    end
    if (ack_rd && lrdy_act) begin
      nxt_rdata = I_LOCAL_READ_DATA_IN;
      nxt_rtrdy = 1'b1;
    end
    case (state_ff)
      ST_IDLE: begin
        if (addr_phase && I_PCI_ADDR_HIT) begin
          nxt_cmd = I_PCI_CBE_N;
          nxt_addr = I_PCI_AD;
          nxt_rd = ~is_write(I_PCI_CBE_N);
          nxt_ben = `PTL_BEN_NONE;
          nxt_rtrdy = 1'b0;
          if (disc_req) begin
            // Retry: claim and stop at once, local frame stays off
            nxt_state = ST_STOP;
            nxt_devsel = 1'b1;
            nxt_stop = 1'b1;
          end else begin
            nxt_state = ST_CLAIM;
            nxt_lframe = 1'b1;
          end
        end
      end
      ST_CLAIM: begin
        // DEVSEL follows the local frame by one clock
        nxt_state = ST_DATA;
        nxt_devsel = 1'b1;
      end
      ST_DATA: begin
        if (abort_req) begin
          nxt_state = ST_ABORT;
          nxt_devsel = 1'b0;
          nxt_stop = 1'b1;
          nxt_rtrdy = 1'b0;
        end else if (disc_req) begin
          // Retry if nothing moved yet, otherwise a disconnect
          nxt_state = ST_STOP;
          nxt_stop = 1'b1;
          nxt_rtrdy = 1'b0;
        end else if (pci_xfer && !frame_act) begin
          nxt_state = ST_DRAIN;
          nxt_devsel = 1'b0;
          nxt_turn = 1'b1;
          nxt_rtrdy = 1'b0;
        end
      end
      ST_STOP, ST_ABORT: begin
        nxt_rtrdy = 1'b0;
        if (!frame_act) begin
          nxt_state = ST_DRAIN;
          nxt_devsel = 1'b0;
          nxt_stop = 1'b0;
          nxt_turn = 1'b1;
        end
      end
      ST_DRAIN: begin
        // Local frame ends once buffered write data has left
        if (rd_ff || !fifo_out_valid) begin
          nxt_state = ST_IDLE;
          nxt_lframe = 1'b0;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_lframe = 1'b0;
        nxt_devsel = 1'b0;
        nxt_stop = 1'b0;
        nxt_rtrdy = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      state_ff <= ST_IDLE;
      lframe_ff <= 1'b0;
      devsel_ff <= 1'b0;
      stop_ff <= 1'b0;
      turn_ff <= 1'b0;
      rtrdy_ff <= 1'b0;
      rd_ff <= 1'b0;
      cmd_ff <= `PTL_RST_CMD;
      addr_ff <= `PTL_RST_ADDR;
      rdata_ff <= `PTL_RST_DATA;
      ben_ff <= `PTL_BEN_NONE;
      irdy_n_ff <= 1'b1;
      frame_d_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      lframe_ff <= nxt_lframe;
      devsel_ff <= nxt_devsel;
      stop_ff <= nxt_stop;
      turn_ff <= nxt_turn;
      rtrdy_ff <= nxt_rtrdy;
      rd_ff <= nxt_rd;
      cmd_ff <= nxt_cmd;
      addr_ff <= nxt_addr;
      rdata_ff <= nxt_rdata;
      ben_ff <= nxt_ben;
      irdy_n_ff <= I_PCI_IRDY_N;
      frame_d_ff <= frame_act;
    end
  end

  // ----------------------------------------------------------------
  // Write data buffer
  // ----------------------------------------------------------------
  ptl_fifo #(
    .WIDTH(`PTL_FIFO_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_wr_fifo (
    .i_clk(I_REF_CLK),
    .i_nrst(I_NRST),
    .i_in_valid(fifo_push),
    .o_in_ready(fifo_in_ready),
    .i_in_data({I_PCI_CBE_N, I_PCI_AD}),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(local_xfer),
    .o_out_data(fifo_out_data)
  );

  // ----------------------------------------------------------------
  // PCI outputs
  // ----------------------------------------------------------------
  assign O_PCI_AD = rdata_ff;
  assign O_PCI_AD_OE = rd_ff & (in_data | (state_ff == ST_STOP) | (state_ff == ST_ABORT));
  assign O_PCI_DEVSEL_N = ~devsel_ff;
  assign O_PCI_TRDY_N = ~trdy_act;
  assign O_PCI_STOP_N = ~stop_ff;
  // Control lines driven while claimed plus one turnaround cycle
  assign O_PCI_CTRL_OE = devsel_ff | stop_ff | turn_ff | in_data;

  // ----------------------------------------------------------------
  // Local outputs
  // ----------------------------------------------------------------
  assign O_LOCAL_TRANSACTION_FRAME_N = ~lframe_ff;
  assign O_CORE_ACKNOWLEDGE_N = ~ack_act;
  assign O_LOCAL_IRDY_REG_N = irdy_n_ff;
  assign O_LOCAL_WRITE_DATA_OUT = fifo_out_data[31:0];
  assign O_LOCAL_TARGET_ADDRESS = addr_ff;
  assign O_LOCAL_BUS_COMMAND = cmd_ff;
  assign O_LOCAL_BYTE_ENABLES_N = rd_ff ? ben_ff : fifo_out_data[35:32];

endmodule // ptl_target_local

// ---- bench/ptl_target_local_sva.sv ----
/*
 Checker for the target local interface, watching top-level ports only.
 Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module ptl_target_local_sva (
  input wire I_REF_CLK,
  input wire I_NRST,
  input wire I_PCI_IRDY_N,
  input wire [31:0] I_PCI_AD,
  input wire [3:0] I_PCI_CBE_N,
  input wire I_LOCAL_READY_N,
  input wire I_LOCAL_ABORT_REQUEST_N,
  input wire O_PCI_DEVSEL_N,
  input wire O_PCI_TRDY_N,
  input wire O_PCI_STOP_N,
  input wire O_LOCAL_TRANSACTION_FRAME_N,
  input wire O_CORE_ACKNOWLEDGE_N,
  input wire O_LOCAL_IRDY_REG_N,
  input wire [31:0] O_LOCAL_TARGET_ADDRESS,
  input wire [3:0] O_LOCAL_BUS_COMMAND
);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_NRST);
  chk_irdy_copy: assert property (O_LOCAL_IRDY_REG_N == $past(I_PCI_IRDY_N))
    else $error("irdy copy wrong");
  chk_frame_lead: assert property ($fell(O_LOCAL_TRANSACTION_FRAME_N) |=> $fell(O_PCI_DEVSEL_N))
    else $error("devsel not one clock after frame");
  chk_retry_noframe: assert property ($fell(O_PCI_DEVSEL_N) && !O_PCI_STOP_N
    |-> O_LOCAL_TRANSACTION_FRAME_N) else $error("frame asserted on retry");
  chk_frame_hold: assert property (!O_PCI_DEVSEL_N && O_PCI_STOP_N
    |-> !O_LOCAL_TRANSACTION_FRAME_N) else $error("frame dropped early");
  chk_addr_step: assert property (!O_CORE_ACKNOWLEDGE_N && !I_LOCAL_READY_N
    |=> O_LOCAL_TARGET_ADDRESS == $past(O_LOCAL_TARGET_ADDRESS) + 32'h4)
    else $error("address not stepped");
  chk_addr_hold: assert property ((O_CORE_ACKNOWLEDGE_N || I_LOCAL_READY_N)
    && !O_LOCAL_TRANSACTION_FRAME_N
    |=> O_LOCAL_TRANSACTION_FRAME_N || $stable(O_LOCAL_TARGET_ADDRESS))
    else $error("address moved without transfer");
  chk_cmd_take: assert property ($fell(O_LOCAL_TRANSACTION_FRAME_N)
    |-> O_LOCAL_BUS_COMMAND == $past(I_PCI_CBE_N) && O_LOCAL_TARGET_ADDRESS == $past(I_PCI_AD))
    else $error("command or address not from address phase");
  chk_stop_notrdy: assert property (!O_PCI_STOP_N |-> O_PCI_TRDY_N)
    else $error("trdy with stop");
  chk_wr_wait: assert property (!O_PCI_TRDY_N && O_LOCAL_BUS_COMMAND[0]
    |-> !I_LOCAL_READY_N) else $error("write trdy without local ready");
  chk_abort_stop: assert property (!I_LOCAL_ABORT_REQUEST_N && !O_PCI_DEVSEL_N && O_PCI_STOP_N
    |=> O_PCI_DEVSEL_N && !O_PCI_STOP_N) else $error("no target abort");
endmodule // ptl_target_local_sva

bind ptl_target_local ptl_target_local_sva u_chk (.I_REF_CLK, .I_NRST, .I_PCI_IRDY_N,
  .I_PCI_AD, .I_PCI_CBE_N, .I_LOCAL_READY_N, .I_LOCAL_ABORT_REQUEST_N, .O_PCI_DEVSEL_N,
  .O_PCI_TRDY_N, .O_PCI_STOP_N, .O_LOCAL_TRANSACTION_FRAME_N, .O_CORE_ACKNOWLEDGE_N,
  .O_LOCAL_IRDY_REG_N, .O_LOCAL_TARGET_ADDRESS, .O_LOCAL_BUS_COMMAND);

// ---- bench/ptl_local_model.sv ----
/*
 Local peripheral model: ready handshake and address-derived read data.
 Assumes it is driven from the same clock as the interface.
*/
`timescale 1ns/1ps
module ptl_local_model #(
  parameter [31:0] KEY = 32'h5a5a_0000
) (
  input wire i_clk,
  input wire i_nrst,
  input wire i_slow,
  input wire i_frame_n,
  input wire i_ack_n,
  input wire [31:0] i_addr,
  output wire o_ready_n,
  output wire [31:0] o_rdata
);
  reg rdy_n_ff;
  reg took_ff;
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) took_ff <= 1'b0;
    else took_ff <= !i_ack_n && !rdy_n_ff;
  end
  // Ready only inside a frame; slow mode rests one cycle after each transfer
  always @(negedge i_clk or negedge i_nrst) begin
    if (!i_nrst) rdy_n_ff <= 1'b1;
    else rdy_n_ff <= i_frame_n || (i_slow && took_ff);
  end
  assign o_ready_n = rdy_n_ff;
  // Word follows the address, so it holds until a transfer; inverted when not ready
  assign o_rdata = rdy_n_ff ? ~(i_addr ^ KEY) : (i_addr ^ KEY);
endmodule // ptl_local_model

// ---- bench/testbench.sv ----
/*
 Self-checking bench: PCI master driven by tasks, local side by the model.
 Assumes the checker and model files are compiled before this one.
*/
`timescale 1ns/1ps
module testbench;
  localparam [31:0] KEY = 32'h5a5a_0000;
  reg clk, nrst, frame_n, irdy_n, hit, abort_n, disc_n, slow, stop_seen, dev_at_stop;
  reg [31:0] ad;
  reg [3:0] cbe_n;
  wire rdy_n, lfrm_n, ack_n, devsel_n, trdy_n, stop_n;
  wire [31:0] rdata, wdata, laddr, pci_ad;
  wire [3:0] lcmd, lben;
  integer fails, checked, lc, got;
  reg [31:0] lw [0:15];
  reg [31:0] la [0:15];
  reg [3:0] lb [0:15];
  reg [31:0] rd [0:15];

  ptl_target_local u_dut (.I_REF_CLK(clk), .I_NRST(nrst), .I_PCI_FRAME_N(frame_n),
    .I_PCI_IRDY_N(irdy_n), .I_PCI_AD(ad), .I_PCI_CBE_N(cbe_n), .I_PCI_ADDR_HIT(hit),
    .O_PCI_AD(pci_ad), .O_PCI_AD_OE(), .O_PCI_DEVSEL_N(devsel_n), .O_PCI_TRDY_N(trdy_n),
    .O_PCI_STOP_N(stop_n), .O_PCI_CTRL_OE(), .I_LOCAL_READ_DATA_IN(rdata),
    .I_LOCAL_READY_N(rdy_n), .I_LOCAL_ABORT_REQUEST_N(abort_n),
    .I_LOCAL_DISCONNECT_REQUEST_N(disc_n), .O_LOCAL_TRANSACTION_FRAME_N(lfrm_n),
    .O_CORE_ACKNOWLEDGE_N(ack_n), .O_LOCAL_IRDY_REG_N(), .O_LOCAL_WRITE_DATA_OUT(wdata),
    .O_LOCAL_TARGET_ADDRESS(laddr), .O_LOCAL_BUS_COMMAND(lcmd), .O_LOCAL_BYTE_ENABLES_N(lben));
  ptl_local_model #(.KEY(KEY)) u_local (.i_clk(clk), .i_nrst(nrst), .i_slow(slow),
    .i_frame_n(lfrm_n), .i_ack_n(ack_n), .i_addr(laddr), .o_ready_n(rdy_n), .o_rdata(rdata));

  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // Local write transfers as the peripheral sees them, sampled settled before the edge
  always begin
    @(negedge clk);
    #4;
    if (!ack_n && !rdy_n && lcmd[0] && lc < 16) begin
      lw[lc] = wdata;
      la[lc] = laddr;
      lb[lc] = lben;
      lc = lc + 1;
    end
  end

  task chk(input string nm, input [31:0] exp, input [31:0] seen);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask

  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  // Mode 0 plain, 1 retry request, 2 disconnect in data, 3 abort in data
  task xfer(input [3:0] cmd, input [31:0] addr, input integer n, input integer mode);
    integer k, w;
    begin
      k = 0;
      w = 0;
      stop_seen = 0;
      lc = 0;
      @(negedge clk);
      frame_n = 0; ad = addr; cbe_n = cmd; hit = 1; disc_n = (mode != 1);
      @(negedge clk);
      hit = 0; irdy_n = 0; cbe_n = 4'h3; frame_n = (n == 1); ad = 32'hc0de_0000;
      disc_n = !(mode == 1 || mode == 2); abort_n = (mode != 3);
      while (k < n && !stop_seen && w < 60) begin
        #4;
        w = w + 1;
        if (!trdy_n) begin
          rd[k] = pci_ad;
          k = k + 1;
        end
        if (!stop_n) begin
          stop_seen = 1;
          dev_at_stop = devsel_n;
        end
        @(negedge clk);
        frame_n = stop_seen || (k >= n - 1);
        ad = 32'hc0de_0000 + k;
      end
      if (stop_seen) @(negedge clk);
      irdy_n = 1; disc_n = 1; abort_n = 1; got = k;
      w = 0;
      while (!lfrm_n && w < 40) begin
        @(negedge clk);
        w = w + 1;
      end
      repeat (2) @(negedge clk);
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_write;
    integer i;
    begin
      slow = 1;
      xfer(4'h7, 32'h0000_1000, 4, 0);
      chk("write count", 4, got);
      chk("write command", 4'h7, lcmd);
      chk("local words", 4, lc);
      for (i = 0; i < 4; i = i + 1) begin
        chk("write data", 32'hc0de_0000 + i, lw[i]);
        chk("write addr", 32'h0000_1000 + 4 * i, la[i]);
        chk("byte enables", 4'h3, lb[i]);
      end
      $display("write burst done");
    end
  endtask

  task t_read;
    integer i, s;
    begin
      for (s = 0; s < 2; s = s + 1) begin
        slow = (s == 1);
        xfer(4'h6, 32'h0000_2000, 3, 0);
        chk("read count", 3, got);
        chk("read command", 4'h6, lcmd);
        for (i = 0; i < 3; i = i + 1)
          chk("read data", (32'h0000_2000 + 4 * i) ^ KEY, rd[i]);
      end
      $display("read bursts done");
    end
  endtask

  task t_stops;
    begin
      slow = 0;
      xfer(4'h6, 32'h0000_3000, 2, 1);
      chk("retry stop", 1, stop_seen);
      chk("retry data", 0, got);
      chk("retry devsel", 0, dev_at_stop);
      xfer(4'h7, 32'h0000_4000, 6, 3);
      chk("abort stop", 1, stop_seen);
      chk("abort devsel", 1, dev_at_stop);
      xfer(4'h6, 32'h0000_5000, 6, 2);
      chk("disc stop", 1, stop_seen);
      chk("disc devsel", 0, dev_at_stop);
      chk("disc short", 1, got < 6);
      $display("terminations done");
    end
  endtask

  initial begin
    nrst = 0; frame_n = 1; irdy_n = 1; hit = 0; abort_n = 1; disc_n = 1; slow = 0;
    ad = 32'h0; cbe_n = 4'hf; fails = 0; checked = 0; lc = 0;
    repeat (12) @(negedge clk);
    nrst = 1;
    chk("idle frame", 1, lfrm_n);
    t_write;
    t_read;
    t_stops;
    tally_and_finish;
  end

  initial begin
    #200000;
    fails = fails + 1;
    tally_and_finish;
  end
endmodule // testbench
